// *** ufit_pkg.sv ***
// package: register map, field layout, reset values and timing of the frame interval timer
package ufit_pkg;
  localparam logic [7:0] INTERVAL_REG_OFS = 8'h34;
  localparam logic [7:0] REMAINING_REG_OFS = 8'h38;
  localparam logic [7:0] CONTROL_REG_OFS = 8'h3C;
  localparam int FRAME_LENGTH_LSB = 0;
  localparam int FRAME_LENGTH_W = 14;
  localparam int PACKET_BUDGET_LSB = 16;
  localparam int PACKET_BUDGET_W = 15;
  localparam int TOGGLE_BIT = 31;
  localparam logic [13:0] FRAME_LENGTH_RST = 14'h2EDF;
  localparam logic [14:0] PACKET_BUDGET_RST = 15'h0000;
  localparam logic [13:0] REMAINING_RST = 14'h0000;
  localparam int CLK_FREQ_HZ = 50000000;
  localparam int BIT_RATE_HZ = 12000000;
  localparam int ACC_W = 26;
  localparam logic [ACC_W-1:0] BIT_STEP = ACC_W'(BIT_RATE_HZ);
  localparam logic [ACC_W-1:0] BIT_MOD = ACC_W'(CLK_FREQ_HZ);
  typedef enum logic [1:0] {ufit_halted_type_e, ufit_enter_e, ufit_running_e} ufit_state_type;
endpackage : ufit_pkg

// *** ufit_bit_tick.sv ***
// fractional divider giving one-cycle full-speed bit-time enables
module ufit_bit_tick
  import ufit_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  output logic tick_q
);
  logic [ACC_W-1:0] acc_q;
  logic [ACC_W-1:0] acc_d;
  logic tick_d;

  // accumulator must hold clock rate plus one step without wrapping
  if (BIT_RATE_HZ >= CLK_FREQ_HZ ||
      CLK_FREQ_HZ + BIT_RATE_HZ >= 2 ** ACC_W) begin : g_rate_check
    $error("bit rate must be below clock rate and fit the accumulator");
  end

  always_comb begin
    if (acc_q + BIT_STEP >= BIT_MOD) begin
      acc_d = acc_q + BIT_STEP - BIT_MOD;
      tick_d = 1'b1;
    end else begin
      acc_d = acc_q + BIT_STEP;
      tick_d = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q <= '0;
      tick_q <= 1'b0;
    end else begin
      acc_q <= acc_d;
      tick_q <= tick_d;
    end
  end
endmodule // ufit_bit_tick

// *** ufit_timer.sv ***
// frame interval register and frame remaining down counter behind an apb slave
// What this block and its driver do
// R1 - frame_length is 14 bits at interval register bits 13..0
// R2 - reset loads frame_length 11999, all other interval bits zero
// R3 - driver inverts interval_toggle each time it writes frame_length
// R4 - packet budget counter loads from bits 30..16 at every frame start
// R5 - driver computes packet_budget as largest overrun-free transaction size
// R6 - driver saves frame_length before reset and restores it afterwards
// R7 - driver may trim frame_length at each frame start
// R8 - remaining_count is 14 bits, decrements once per bit time
// R9 - at zero remaining_count reloads frame_length on next bit time
// R10 - at zero remaining_toggle copies interval_toggle
// R11 - entering operational_state reloads remaining_count from frame_length
// R12 - driver writes reserved bits as zero
// R13 - every reload of remaining_count pulses the frame boundary
// R14 - a one-cycle 12 Mbit/s bit-time enable clocks the counter
module ufit_timer
  import ufit_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic frame_boundary_q,
  output logic [14:0] budget_count_q,
  output logic operational_q
);
  logic bit_tick;
  logic [13:0] frame_length_q, frame_length_d;
  logic [14:0] packet_budget_q, packet_budget_d;
  logic interval_toggle_q, interval_toggle_d;
  logic [13:0] remaining_q, remaining_d;
  logic remaining_toggle_q, remaining_toggle_d;
  logic frame_boundary_d;
  logic [14:0] budget_count_d;
  logic operational_d;
  ufit_state_type state_q, state_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  logic access, wr;
  logic wr_remaining;

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  ufit_bit_tick u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .tick_q(bit_tick)
  );

  // access phase seen in the first cycle; answer lands one edge later
  assign access = psel && penable && !pready_q;
  assign wr = access && pwrite;
  assign wr_remaining = wr && paddr == REMAINING_REG_OFS;

  function automatic logic [31:0] read_word(input logic [7:0] a, input logic [13:0] fl,
      input logic [14:0] pb, input logic it, input logic [13:0] rm, input logic rt,
      input logic op);
    read_word = 32'h0000_0000;
    if (a == INTERVAL_REG_OFS) begin
      read_word = {it, pb, 2'b00, fl};
    end else if (a == REMAINING_REG_OFS) begin
      read_word = {rt, 17'h00000, rm};
    end else if (a == CONTROL_REG_OFS) begin
      read_word = {31'h0000_0000, op};
    end
  endfunction

  // register writes
  always_comb begin
    frame_length_d = frame_length_q;
    packet_budget_d = packet_budget_q;
    interval_toggle_d = interval_toggle_q;
    operational_d = operational_q;
    if (wr && paddr == INTERVAL_REG_OFS) begin
      frame_length_d = pwdata[FRAME_LENGTH_LSB +: FRAME_LENGTH_W]; // R1
      packet_budget_d = pwdata[PACKET_BUDGET_LSB +: PACKET_BUDGET_W];
      interval_toggle_d = pwdata[TOGGLE_BIT];
    end else if (wr && paddr == CONTROL_REG_OFS) begin
      operational_d = pwdata[0];
    end
  end

  // counter and operational state
  always_comb begin
    state_d = state_q;
    remaining_d = remaining_q;
    remaining_toggle_d = remaining_toggle_q;
    frame_boundary_d = 1'b0;
    budget_count_d = budget_count_q;
    case (state_q)
      ufit_halted_type_e: begin
        if (operational_q) begin
          state_d = ufit_enter_e;
        end
      end
      ufit_enter_e: begin
        remaining_d = frame_length_q; // R11
        frame_boundary_d = 1'b1; // R13
        budget_count_d = packet_budget_q; // R4
        state_d = ufit_running_e;
      end
      ufit_running_e: begin
        if (!operational_q) begin
          state_d = ufit_halted_type_e;
        end else if (bit_tick) begin // R14
          if (remaining_q == 14'h0000) begin
            remaining_d = frame_length_q; // R9
            remaining_toggle_d = interval_toggle_q; // R10
            frame_boundary_d = 1'b1; // R13
            budget_count_d = packet_budget_q; // R4
          end else begin
            remaining_d = remaining_q - 14'h0001; // R8
          end
        end
      end
      default: state_d = ufit_halted_type_e;
    endcase
    if (wr && paddr == REMAINING_REG_OFS) begin
      remaining_d = pwdata[13:0];
      remaining_toggle_d = pwdata[TOGGLE_BIT];
    end
  end

  always_comb begin
    pready_d = access;
    pslverr_d = 1'b0;
    prdata_d = 32'h0000_0000;
    if (access) begin
      prdata_d = read_word(paddr, frame_length_q, packet_budget_q, interval_toggle_q,
          remaining_q, remaining_toggle_q, operational_q);
      pslverr_d = !(paddr == INTERVAL_REG_OFS || paddr == REMAINING_REG_OFS ||
          paddr == CONTROL_REG_OFS);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_length_q <= FRAME_LENGTH_RST; // R2
      packet_budget_q <= PACKET_BUDGET_RST;
      interval_toggle_q <= 1'b0;
      operational_q <= 1'b0;
      state_q <= ufit_halted_type_e;
      remaining_q <= REMAINING_RST;
      remaining_toggle_q <= 1'b0;
      frame_boundary_q <= 1'b0;
      budget_count_q <= PACKET_BUDGET_RST;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      frame_length_q <= frame_length_d;
      packet_budget_q <= packet_budget_d;
      interval_toggle_q <= interval_toggle_d;
      operational_q <= operational_d;
      state_q <= state_d;
      remaining_q <= remaining_d;
      remaining_toggle_q <= remaining_toggle_d;
      frame_boundary_q <= frame_boundary_d;
      budget_count_q <= budget_count_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  sequence zero_tick_s;
    state_q == ufit_running_e && operational_q && bit_tick && remaining_q == 14'h0000 &&
        !(wr && paddr == REMAINING_REG_OFS);
  endsequence

  reload_value_a: assert property (@(posedge pclk) disable iff (!presetn) // R9
      zero_tick_s |=> remaining_q == $past(frame_length_q))
    else $error("counter did not reload frame length");
  toggle_copy_a: assert property (@(posedge pclk) disable iff (!presetn) // R10
      zero_tick_s |=> remaining_toggle_q == $past(interval_toggle_q))
    else $error("toggle not copied at zero");
  boundary_pulse_a: assert property (@(posedge pclk) disable iff (!presetn) // R13
      zero_tick_s |=> frame_boundary_q ##1 !frame_boundary_q)
    else $error("frame boundary pulse missing");
  budget_load_a: assert property (@(posedge pclk) disable iff (!presetn) // R4
      frame_boundary_q |-> budget_count_q == $past(packet_budget_q))
    else $error("budget counter not loaded");
  count_down_a: assert property (@(posedge pclk) disable iff (!presetn) // R8
      state_q == ufit_running_e && operational_q && bit_tick && remaining_q != 14'h0000 &&
      !(wr && paddr == REMAINING_REG_OFS) |=> remaining_q == $past(remaining_q) - 14'h0001)
    else $error("counter did not decrement");
  hold_no_tick_a: assert property (@(posedge pclk) disable iff (!presetn) // R14
      state_q == ufit_running_e && !bit_tick && !wr |=> remaining_q == $past(remaining_q))
    else $error("counter moved without bit time");
  enter_reload_a: assert property (@(posedge pclk) disable iff (!presetn) // R11
      state_q == ufit_halted_type_e && operational_q && !wr ##1 !wr
      |=> remaining_q == $past(frame_length_q) && frame_boundary_q)
    else $error("no reload on entering operation");
  length_field_a: assert property (@(posedge pclk) disable iff (!presetn) // R1
      wr && paddr == INTERVAL_REG_OFS |=> frame_length_q == $past(pwdata[13:0]))
    else $error("frame length not written");
  reset_value_a: assert property (@(posedge pclk) // R2
      $rose(presetn) |-> frame_length_q == FRAME_LENGTH_RST &&
      packet_budget_q == PACKET_BUDGET_RST && !interval_toggle_q)
    else $error("bad interval reset value");

  // reload, budget and toggle only move at frame boundaries; the toggle also moves on a remaining register write
  sequence reload_s;
    frame_boundary_q && !$past(wr_remaining);
  endsequence

  reload_source_a: assert property (@(posedge pclk) disable iff (!presetn) // R13
      reload_s |-> remaining_q == $past(frame_length_q))
    else $error("boundary pulse without reload");
  budget_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // R4
      !frame_boundary_q |-> $stable(budget_count_q))
    else $error("budget counter moved between frames");
  halted_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // R8
      state_q == ufit_halted_type_e && !wr_remaining |=> $stable(remaining_q))
    else $error("counter moved while halted");
  toggle_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // R10
      !frame_boundary_q && !$past(wr_remaining) |-> $stable(remaining_toggle_q))
    else $error("remaining toggle moved between frames");
endmodule // ufit_timer

// *** test_usb_frame_interval_timer.sv ***
// self-checking bench for the frame interval timer over apb
module test_usb_frame_interval_timer
  import ufit_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, frame_boundary_q, operational_q, err;
  logic [14:0] budget_count_q;
  int n_mismatch = 0;
  int checks = 0;
  int cycles = 0;
  int t1, t2;

  ufit_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .frame_boundary_q(frame_boundary_q),
    .budget_count_q(budget_count_q), .operational_q(operational_q));

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task automatic report_and_stop();
    if (n_mismatch == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // one apb transfer; request held until pready is sampled high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(32'(n), 32'h2, "ready latency");
  endtask

  // cycle stamp of the next frame boundary pulse, which lasts one cycle
  task automatic boundary(output int t);
    do begin
      @(negedge pclk);
    end while (frame_boundary_q !== 1'b1);
    t = cycles;
    @(negedge pclk);
    chk(32'(frame_boundary_q), 32'h0, "boundary width");
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, INTERVAL_REG_OFS, 32'h0);
    chk(rd, 32'h00002EDF, "interval reset");
    apb(1'b0, REMAINING_REG_OFS, 32'h0);
    chk(rd, 32'h0, "remaining reset");
    apb(1'b0, 8'h40, 32'h0);
    chk({err, rd[30:0]}, 32'h80000000, "unmapped read");
    apb(1'b1, INTERVAL_REG_OFS, 32'h80050004);
    apb(1'b0, INTERVAL_REG_OFS, 32'h0);
    chk(rd, 32'h80050004, "interval readback");
    apb(1'b1, CONTROL_REG_OFS, 32'h1);
    chk(32'(operational_q), 32'h1, "operational");
    boundary(t1);
    boundary(t1);
    boundary(t2);
    chk(32'((t2 - t1) inside {[20:21]}), 32'h1, "frame 5 bits");
    chk(32'(budget_count_q), 32'h5, "budget");
    apb(1'b0, REMAINING_REG_OFS, 32'h0);
    chk(rd & 32'hFFFFC000, 32'h80000000, "remaining toggle");
    chk(32'(rd[13:0] <= 14'd4), 32'h1, "remaining range");
    apb(1'b1, INTERVAL_REG_OFS, 32'h00070008);
    boundary(t1);
    boundary(t2);
    chk(32'((t2 - t1) inside {[37:38]}), 32'h1, "frame 9 bits");
    chk(32'(budget_count_q), 32'h7, "budget update");
    apb(1'b0, REMAINING_REG_OFS, 32'h0);
    chk(32'(rd[31]), 32'h0, "toggle copy");
    boundary(t1);
    apb(1'b1, INTERVAL_REG_OFS, 32'h80070009);
    boundary(t1);
    boundary(t2);
    chk(32'((t2 - t1) inside {[41:42]}), 32'h1, "frame 10 bits");
    apb(1'b1, CONTROL_REG_OFS, 32'h0);
    apb(1'b0, REMAINING_REG_OFS, 32'h0);
    t1 = int'(rd);
    repeat (20) @(posedge pclk);
    apb(1'b0, REMAINING_REG_OFS, 32'h0);
    chk(rd, 32'(t1), "halted hold");
    apb(1'b1, REMAINING_REG_OFS, 32'h80000123);
    apb(1'b0, REMAINING_REG_OFS, 32'h0);
    chk(rd, 32'h80000123, "remaining write");
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, INTERVAL_REG_OFS, 32'h0);
    chk(rd, 32'h00002EDF, "reset again");
    apb(1'b1, INTERVAL_REG_OFS, 32'h00070008);
    apb(1'b0, INTERVAL_REG_OFS, 32'h0);
    chk(rd, 32'h00070008, "restore");
    report_and_stop();
  end
endmodule // test_usb_frame_interval_timer
